// [common/drpes_pkg.sv]
// package: constants and types for the dual radio power enable sequencer
package drpes_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned POR_HOLD_MS    = 110;
    localparam int unsigned HOST_WAIT_MS   = 150;
    localparam int unsigned DISCHARGE_MS   = 10;
    // longest time fits the 32 bit counters; figures are exact at this rate
    localparam int unsigned POR_HOLD_CYC   = (CLK_HZ / 1000) * POR_HOLD_MS;
    localparam int unsigned HOST_WAIT_CYC  = (CLK_HZ / 1000) * HOST_WAIT_MS;
    localparam int unsigned DISCHARGE_CYC  = (CLK_HZ / 1000) * DISCHARGE_MS;
    localparam int unsigned CNT_W          = 32;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_REG_EN   = 1'b0;
    localparam logic RST_SEC_RSTN = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_OFF = 3'b001,
        ST_POR = 3'b010,
        ST_RUN = 3'b100
    } drpes_state_t;

    typedef struct packed
    {
        logic wlan_power_enable;
        logic radio_link_power_enable;
    } drpes_en_t;

    typedef struct packed
    {
        logic regulator_en;
        logic wlan_rst_n;
        logic radio_rst_n;
        logic por_active;
        logic host_ready;
        logic discharge_busy;
    } drpes_out_t;
endpackage : drpes_pkg

// [logic/drpes_sync.sv]
// two flop synchroniser for the enable pins
`timescale 1ns/1ps
`default_nettype none
module drpes_sync
#(
    parameter int unsigned W = 2
)
(
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // ------------------------------------------------------------
    // next values; first stage read only by the second
    // ------------------------------------------------------------
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // drpes_sync
`default_nettype wire

// [logic/drpes_top.sv]
// power and reset sequencer driven by two host enable pins
// Notes on behaviour
// - regulators are on whenever either enable input is high.
// - with the wlan enable high the regulators stay on and wlan leaves reset.
// - with the wlan enable low the wlan section is held in reset.
// - with both enables low all regulators are switched off.
// - with radio enable low and wlan enable high the radio section is in reset.
// - internal power-on reset lasts at most 110 ms after supplies are up.
`timescale 1ns/1ps
`default_nettype none
module drpes_top
    import drpes_pkg::*;
#(
    parameter int unsigned POR_CYC  = drpes_pkg::POR_HOLD_CYC,
    parameter int unsigned WAIT_CYC = drpes_pkg::HOST_WAIT_CYC,
    parameter int unsigned DIS_CYC  = drpes_pkg::DISCHARGE_CYC
)
(
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire drpes_pkg::drpes_en_t en_pins,
    output drpes_pkg::drpes_out_t     status
);
    import drpes_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [1:0] en_sync;
    drpes_en_t  en_s;

    drpes_sync #(.W(2)) u_sync
    (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in (en_pins),
        .sync_out (en_sync)
    );

    assign en_s = drpes_en_t'(en_sync);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    drpes_state_t     state_q;
    drpes_state_t     state_d;
    logic [CNT_W-1:0] por_cnt_q;
    logic [CNT_W-1:0] por_cnt_d;
    logic [CNT_W-1:0] up_cnt_q;
    logic [CNT_W-1:0] up_cnt_d;
    logic [CNT_W-1:0] dis_cnt_q;
    logic [CNT_W-1:0] dis_cnt_d;
    drpes_out_t       out_q;
    drpes_out_t       out_d;
    logic             any_en;

    assign any_en = en_s.wlan_power_enable | en_s.radio_link_power_enable;

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d   = state_q;
        por_cnt_d = por_cnt_q;
        up_cnt_d  = up_cnt_q;
        dis_cnt_d = (dis_cnt_q != '0) ? dis_cnt_q - 1'b1 : dis_cnt_q;
        unique case (state_q)
            ST_OFF:
            begin
                if (any_en)
                begin
                    // fresh hold on every cold start
                    state_d   = ST_POR;
                    por_cnt_d = '0;
                    up_cnt_d  = '0;
                end
            end
            ST_POR:
            begin
                up_cnt_d = up_cnt_q + 1'b1;
                if (!any_en)
                begin
                    state_d   = ST_OFF;
                    dis_cnt_d = CNT_W'(DIS_CYC);
                end
                else if (por_cnt_q >= CNT_W'(POR_CYC - 1))
                begin
                    state_d = ST_RUN;
                end
                else
                begin
                    por_cnt_d = por_cnt_q + 1'b1;
                end
            end
            ST_RUN:
            begin
                // saturate once the host window is reached
                if (up_cnt_q < CNT_W'(WAIT_CYC))
                begin
                    up_cnt_d = up_cnt_q + 1'b1;
                end
                if (!any_en)
                begin
                    state_d   = ST_OFF;
                    dis_cnt_d = CNT_W'(DIS_CYC);
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // output next values, all registered
    // ------------------------------------------------------------
    always_comb
    begin
        out_d.regulator_en   = (state_d != ST_OFF);
        out_d.por_active     = (state_d == ST_POR);
        // sections only leave reset once the hold is over
        out_d.wlan_rst_n     = (state_d == ST_RUN) && en_s.wlan_power_enable;
        out_d.radio_rst_n    = (state_d == ST_RUN)
                               && en_s.radio_link_power_enable;
        // advisory only; the host owns these waits
        out_d.host_ready     = (state_d == ST_RUN) && (up_cnt_d >= CNT_W'(WAIT_CYC));
        out_d.discharge_busy = (dis_cnt_d != '0);
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q   <= ST_OFF;
            por_cnt_q <= '0;
            up_cnt_q  <= '0;
            dis_cnt_q <= '0;
            out_q     <= '{RST_REG_EN, RST_SEC_RSTN, RST_SEC_RSTN, 1'b0, 1'b0, 1'b0};
        end
        else
        begin
            state_q   <= state_d;
            por_cnt_q <= por_cnt_d;
            up_cnt_q  <= up_cnt_d;
            dis_cnt_q <= dis_cnt_d;
            out_q     <= out_d;
        end
    end

    assign status = out_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_wlan_rst_low: assert property (@(posedge mclk) disable iff (sys_rst)
        !en_s.wlan_power_enable |=> !status.wlan_rst_n)
        else $error("wlan left reset with enable low");

    a_regs_both_off: assert property (@(posedge mclk) disable iff (sys_rst)
        !any_en |=> !status.regulator_en)
        else $error("regulators on with both enables low");

    a_regs_any_on: assert property (@(posedge mclk) disable iff (sys_rst)
        any_en && state_q != ST_OFF |=> status.regulator_en)
        else $error("regulators off with an enable high");

    a_radio_rst_low: assert property (@(posedge mclk) disable iff (sys_rst)
        !en_s.radio_link_power_enable && en_s.wlan_power_enable |=> !status.radio_rst_n)
        else $error("radio left reset with its enable low");

    a_por_bounded: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == ST_POR |-> por_cnt_q < CNT_W'(POR_CYC))
        else $error("power-on hold too long");

    a_cold_start: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == ST_OFF && any_en |=> status.por_active && !status.wlan_rst_n)
        else $error("cold start skipped reset hold");

    a_wlan_release: assert property (@(posedge mclk) disable iff (sys_rst)
        state_q == ST_RUN && en_s.wlan_power_enable |=> status.wlan_rst_n
        && status.regulator_en)
        else $error("wlan not released while enabled");

    a_ready_after: assert property (@(posedge mclk) disable iff (sys_rst)
        status.host_ready |-> up_cnt_q >= CNT_W'(WAIT_CYC)
        && status.regulator_en && !status.por_active)
        else $error("host ready too early");

    // busy is loaded in the same cycle that the regulators drop
    a_discharge_start: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(status.regulator_en) |-> status.discharge_busy == (DIS_CYC != 0))
        else $error("discharge window not started");

    c_cold_start: cover property (@(posedge mclk) disable iff (sys_rst)
        $rose(status.por_active));
    c_run: cover property (@(posedge mclk) disable iff (sys_rst)
        $rose(status.wlan_rst_n));
    c_ready: cover property (@(posedge mclk) disable iff (sys_rst)
        $rose(status.host_ready));
    c_off: cover property (@(posedge mclk) disable iff (sys_rst)
        $fell(status.regulator_en));
endmodule // drpes_top
`default_nettype wire

// [testbench/drpes_host_model.sv]
// host model: general purpose outputs driving the two enable pins
`timescale 1ns/1ps
`default_nettype none
module drpes_host_model
    import drpes_pkg::*;
#(
    parameter int unsigned DIS_CYC = 10
)
(
    input  wire logic             mclk,
    input  wire logic             want_wlan,
    input  wire logic             want_radio,
    output drpes_pkg::drpes_en_t  en_pins
);
    int unsigned hold_cnt = 0;

    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    // pins move on the falling edge; after both drop the host waits out
    // the discharge span before toggling again, any longer wait is fine
    initial en_pins = '0;
    always @(negedge mclk)
    begin
        if (hold_cnt != 0)
        begin
            hold_cnt <= hold_cnt - 1;
        end
        else
        begin
            en_pins.wlan_power_enable       <= want_wlan;
            en_pins.radio_link_power_enable <= want_radio;
            if ((en_pins != '0) && !want_wlan && !want_radio)
            begin
                hold_cnt <= DIS_CYC + 2;
            end
        end
    end
endmodule // drpes_host_model
`default_nettype wire

// [testbench/tb_dual_radio_power_enable_sequencer.sv]
// self-checking bench for the power enable sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_dual_radio_power_enable_sequencer;
    import drpes_pkg::*;
    localparam int POR = 20;
    localparam int WT  = 40;
    localparam int DIS = 10;

    logic       mclk       = 1'b0;
    logic       sys_rst    = 1'b1;
    logic       want_wlan  = 1'b0;
    logic       want_radio = 1'b0;
    drpes_en_t  en_pins;
    drpes_out_t status;
    int         n_errors   = 0;
    int         tests_run  = 0;
    bit         ok;
    int         n;

    // ------------------------------------------------------------
    // clock, host and design
    // ------------------------------------------------------------
    always #2.5 mclk = ~mclk;

    drpes_host_model #(.DIS_CYC(DIS)) i_host (
        .mclk       (mclk),
        .want_wlan  (want_wlan),
        .want_radio (want_radio),
        .en_pins    (en_pins)
    );

    drpes_top #(.POR_CYC(POR), .WAIT_CYC(WT), .DIS_CYC(DIS)) i_dut (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .en_pins (en_pins),
        .status  (status)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    // bit index into the packed status word, msb is regulator_en
    task automatic wait_bit(input int b, input logic v, input int lim, output bit hit);
        int c;
        c = 0;
        hit = 0;
        while (c <= lim && !hit)
        begin
            @(posedge mclk);
            #1;
            c++;
            hit = (status[b] === v);
        end
        n = c;
    endtask

    task automatic summarize();
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_wlan_up();
        @(negedge mclk) want_wlan <= 1'b1;
        wait_bit(5, 1'b1, 8, ok);
        chk("reg_on", 1'b1, ok);
        chk("por_on", 1'b1, status.por_active);
        chk("wlan_held", 1'b0, status.wlan_rst_n);
        wait_bit(2, 1'b0, POR + 4, ok);
        chk("por_len", 1'b1, ok && n <= POR + 1 && n >= POR - 2);
        wait_bit(4, 1'b1, 3, ok);
        chk("wlan_out", 1'b1, ok);
        chk("radio_held", 1'b0, status.radio_rst_n);
        wait_bit(1, 1'b1, WT, ok);
        chk("host_ready", 1'b1, ok);
    endtask

    task automatic s_swap();
        @(negedge mclk) want_radio <= 1'b1;
        wait_bit(3, 1'b1, 6, ok);
        chk("radio_out", 1'b1, ok);
        @(negedge mclk) want_wlan <= 1'b0;
        wait_bit(4, 1'b0, 6, ok);
        chk("wlan_in", 1'b1, ok);
        chk("reg_radio", 1'b1, status.regulator_en);
        chk("radio_kept", 1'b1, status.radio_rst_n);
    endtask

    task automatic s_off_cold();
        @(negedge mclk) want_radio <= 1'b0;
        wait_bit(5, 1'b0, 6, ok);
        chk("reg_off", 1'b1, ok);
        chk("dis_busy", 1'b1, status.discharge_busy);
        chk("radio_off", 1'b0, status.radio_rst_n);
        chk("ready_off", 1'b0, status.host_ready);
        // busy window spans exactly the discharge count
        wait_bit(0, 1'b0, DIS + 2, ok);
        chk("dis_len", 1'b1, ok && n == DIS);
        @(negedge mclk) want_radio <= 1'b1;
        wait_bit(2, 1'b1, DIS + 12, ok);
        chk("por_again", 1'b1, ok);
        chk("reg_again", 1'b1, status.regulator_en);
        chk("radio_por", 1'b0, status.radio_rst_n);
        wait_bit(3, 1'b1, POR + 4, ok);
        chk("radio_after", 1'b1, ok);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(negedge mclk);
        chk("rst_quiet", 1'b1, status === '0);
        sys_rst = 1'b0;
        s_wlan_up();
        s_swap();
        s_off_cold();
        summarize();
    end

    // the whole run needs about a hundred cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        summarize();
    end
endmodule // tb_dual_radio_power_enable_sequencer
`default_nettype wire
